// >>> mpg_port.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
// Contract
// R1: Eight pins, direction set per bit
// R2: Reset leaves every pin disabled port pin
// R3: Data, enable, function, open-drain offsets decoded
// R4: Pull-up, pull-down, input-enable offsets decoded
// R5: Data in bits 7-0, upper bits zero
// R6: Output-enable bit 1 turns driver on
// R7: Function bit selects port or motor use
// R8: Open-drain bit picks open-drain over push-pull
// R9: Pull-up bit enables internal pull-up
// R10: Pull-down bit enables internal pull-down
// R11: Input-enable bit passes or blocks input
// R12: Enabled port pin drives data bit
module mpg_port (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Motor unit
    input  wire logic        phase_u_in,
    input  wire logic        phase_x_in,
    input  wire logic        phase_v_in,
    input  wire logic        phase_y_in,
    input  wire logic        phase_w_in,
    input  wire logic        phase_z_in,
    output logic             emergency_out,
    output logic             overvoltage_out,
    // Pins
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_out,
    output logic      [7:0]  pull_up_out,
    output logic      [7:0]  pull_down_out
);
    mpg_cfg_if cfg ();

    mpg_pkg::mpg_bus_state_e state;
    mpg_pkg::mpg_bus_state_e next_state;

    logic [7:0] pin_data_reg;
    logic [7:0] output_enable_reg;
    logic [7:0] function_select_reg;
    logic [7:0] open_drain_reg;
    logic [7:0] pull_up_reg;
    logic [7:0] pull_down_reg;
    logic [7:0] input_enable_reg;
    logic [7:0] pin_level;
    logic [7:0] emg_ovv_gate;

    wire        access;
    wire        wr_take;
    wire        rd_take;
    wire        lane0;
    wire        hit_data;
    wire        hit_oe;
    wire        hit_func;
    wire        hit_od;
    wire        hit_pu;
    wire        hit_pd;
    wire        hit_ie;
    wire [7:0]  wbyte;
    wire [7:0]  pin_data_view;
    wire [31:0] next_readdata;
    wire [5:0]  phase_bus;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign hit_data = hit(avs_address_in, mpg_pkg::OFS_PIN_DATA);   // see R3
    assign hit_oe   = hit(avs_address_in, mpg_pkg::OFS_OUT_EN);     // see R3
    assign hit_func = hit(avs_address_in, mpg_pkg::OFS_FUNC_SEL);   // see R3
    assign hit_od   = hit(avs_address_in, mpg_pkg::OFS_OPEN_DRAIN); // see R3
    assign hit_pu   = hit(avs_address_in, mpg_pkg::OFS_PULL_UP);    // see R4
    assign hit_pd   = hit(avs_address_in, mpg_pkg::OFS_PULL_DOWN);  // see R4
    assign hit_ie   = hit(avs_address_in, mpg_pkg::OFS_INPUT_EN);   // see R4

    // ****************************************
    // Bus handshake: one wait cycle, answer in the second
    // ****************************************
    assign access     = avs_read_in | avs_write_in;
    assign next_state = (state == mpg_pkg::MPG_BUS_IDLE && access) ?
                        mpg_pkg::MPG_BUS_DONE : mpg_pkg::MPG_BUS_IDLE;
    assign avs_waitrequest_out = access & (state == mpg_pkg::MPG_BUS_IDLE);
    assign wr_take    = avs_write_in & (state == mpg_pkg::MPG_BUS_DONE);
    assign rd_take    = avs_read_in & (state == mpg_pkg::MPG_BUS_IDLE);
    // Only the low lane carries bits; writes with lane 0 off store nothing
    assign lane0      = avs_byteenable_in[0];
    assign wbyte      = avs_writedata_in[mpg_pkg::DATA_MSB:mpg_pkg::DATA_LSB];

    // Input pins read their sampled level, output pins the data register
    assign pin_data_view = (pin_data_reg & output_enable_reg) |
                           (pin_level & ~output_enable_reg);

    assign next_readdata =
        hit_data ? {24'h000000, pin_data_view}       : // see R5
        hit_oe   ? {24'h000000, output_enable_reg}   :
        hit_func ? {24'h000000, function_select_reg} :
        hit_od   ? {24'h000000, open_drain_reg}      :
        hit_pu   ? {24'h000000, pull_up_reg}         :
        hit_pd   ? {24'h000000, pull_down_reg}       :
        hit_ie   ? {24'h000000, input_enable_reg}    :
                   mpg_pkg::UNMAPPED_READ;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state            <= mpg_pkg::MPG_BUS_IDLE;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            case (state)
                mpg_pkg::MPG_BUS_IDLE: begin
                    state <= next_state;
                end
                mpg_pkg::MPG_BUS_DONE: begin
                    state <= next_state;
                end
                default: begin
                    state <= mpg_pkg::MPG_BUS_IDLE;
                end
            endcase
            if (rd_take) begin
                avs_readdata_out <= next_readdata;
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pin_data_reg        <= mpg_pkg::RST_PORT_REG; // see R2
            output_enable_reg   <= mpg_pkg::RST_PORT_REG; // see R2 R6
            function_select_reg <= mpg_pkg::RST_PORT_REG; // see R2
            open_drain_reg      <= mpg_pkg::RST_PORT_REG; // see R8
            pull_up_reg         <= mpg_pkg::RST_PORT_REG; // see R2
            pull_down_reg       <= mpg_pkg::RST_PORT_REG; // see R2
            input_enable_reg    <= mpg_pkg::RST_PORT_REG; // see R2
        end else if (wr_take && lane0) begin
            if (hit_data) begin
                pin_data_reg <= wbyte; // see R5
            end
            if (hit_oe) begin
                output_enable_reg <= wbyte; // see R1 R6
            end
            if (hit_func) begin
                function_select_reg <= wbyte; // see R7
            end
            if (hit_od) begin
                open_drain_reg <= wbyte; // see R8
            end
            if (hit_pu) begin
                pull_up_reg <= wbyte; // see R9
            end
            if (hit_pd) begin
                pull_down_reg <= wbyte; // see R10
            end
            if (hit_ie) begin
                input_enable_reg <= wbyte; // see R11
            end
        end
    end

    assign cfg.out_en     = output_enable_reg;
    assign cfg.func_sel   = function_select_reg;
    assign cfg.open_drain = open_drain_reg;
    assign cfg.pull_up    = pull_up_reg;
    assign cfg.pull_down  = pull_down_reg;
    assign cfg.input_en   = input_enable_reg;
    assign cfg.pin_data   = pin_data_reg;

    // Pin order of the phases is U, X, V, Y, W, Z, not the unit's U, V, W order
    assign phase_bus = {phase_z_in, phase_w_in, phase_y_in,
                        phase_v_in, phase_x_in, phase_u_in}; // see R7

    // ****************************************
    // Pads
    // ****************************************
    mpg_pad_mux u_pads (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .cfg           (cfg),
        .phase_in      (phase_bus),
        .pin_in        (pin_in),
        .pin_out       (pin_out),
        .pin_oe_out    (pin_oe_out),
        .pull_up_out   (pull_up_out),
        .pull_down_out (pull_down_out),
        .pin_level_out (pin_level)
    );

    // Protection inputs reach the motor unit only when the pin is handed over
    assign emg_ovv_gate = pin_level & function_select_reg;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            emergency_out   <= 1'b0;
            overvoltage_out <= 1'b0;
        end else begin
            emergency_out   <= emg_ovv_gate[mpg_pkg::FUNC_EMG_BIT]; // see R7
            overvoltage_out <= emg_ovv_gate[mpg_pkg::FUNC_OVV_BIT]; // see R7
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_write_oe;
        wr_take && lane0 && hit_oe;
    endsequence
    sequence s_write_data;
        wr_take && lane0 && hit_data;
    endsequence
    sequence s_read_unmapped;
        rd_take && !(hit_data || hit_oe || hit_func || hit_od || hit_pu || hit_pd || hit_ie);
    endsequence

    a_reset_idle: assert property (@(posedge clk_in) // see R2
        !reset_n_in |=> (output_enable_reg == 8'h00 && input_enable_reg == 8'h00
                         && pull_up_reg == 8'h00 && function_select_reg == 8'h00))
        else $error("reset did not clear port setup");
    a_oe_write: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R6
        s_write_oe |=> (output_enable_reg == $past(wbyte)))
        else $error("output enable write lost");
    a_data_write: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R5
        s_write_data |=> (pin_data_reg == $past(wbyte)))
        else $error("data register write lost");
    a_lane_refused: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R3
        (wr_take && !lane0) |=> $stable({pin_data_reg, output_enable_reg, open_drain_reg,
                                         pull_up_reg, pull_down_reg, input_enable_reg}))
        else $error("write without low lane changed a register");
    a_oe_to_pin: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R1 R6
        s_write_oe ##1 (function_select_reg == 8'h00 && open_drain_reg == 8'h00)
        |=> (pin_oe_out == $past(output_enable_reg)))
        else $error("pin driver does not follow enable");
    a_port_drive: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R12
        (output_enable_reg[0] && !function_select_reg[0] && !open_drain_reg[0])
        |=> (pin_oe_out[0] && pin_out[0] == $past(pin_data_reg[0])))
        else $error("port pin not driven with data");
    a_open_drain: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R8
        (open_drain_reg[1] && !function_select_reg[1] && pin_data_reg[1])
        |=> !pin_oe_out[1])
        else $error("open drain pin drives high");
    a_upper_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R5
        rd_take |=> (avs_readdata_out[31:8] == 24'h000000))
        else $error("upper bits read nonzero");
    a_read_data: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R5
        (rd_take && hit_data) |=> (avs_readdata_out[7:0] == $past(pin_data_view)))
        else $error("data register read wrong");
    a_read_oe: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R3
        (rd_take && hit_oe) |=> (avs_readdata_out[7:0] == $past(output_enable_reg)))
        else $error("output enable read wrong");
    a_read_func: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R3
        (rd_take && hit_func) |=> (avs_readdata_out[7:0] == $past(function_select_reg)))
        else $error("function register read wrong");
    a_read_od: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R3
        (rd_take && hit_od) |=> (avs_readdata_out[7:0] == $past(open_drain_reg)))
        else $error("open drain read wrong");
    a_read_pu: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R4
        (rd_take && hit_pu) |=> (avs_readdata_out[7:0] == $past(pull_up_reg)))
        else $error("pull-up read wrong");
    a_read_pd: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R4
        (rd_take && hit_pd) |=> (avs_readdata_out[7:0] == $past(pull_down_reg)))
        else $error("pull-down read wrong");
    a_read_ie: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R4
        (rd_take && hit_ie) |=> (avs_readdata_out[7:0] == $past(input_enable_reg)))
        else $error("input enable read wrong");
    a_unmapped_read: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R3
        s_read_unmapped |=> (avs_readdata_out == mpg_pkg::UNMAPPED_READ))
        else $error("unmapped read not zero");
    a_wait_bound: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R3
        $rose(access) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("bus answer not in one wait");
    a_wait_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R3
        !access |-> !avs_waitrequest_out)
        else $error("wait raised without a request");
    a_phase_u: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R7
        (function_select_reg[0] && !open_drain_reg[0]) |=> (pin_out[0] == $past(phase_u_in)))
        else $error("phase u not routed");
    a_phase_x: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R7
        (function_select_reg[1] && !open_drain_reg[1]) |=> (pin_out[1] == $past(phase_x_in)))
        else $error("phase x not routed");
    a_phase_z: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R7
        (function_select_reg[5] && !open_drain_reg[5]) |=> (pin_out[5] == $past(phase_z_in)))
        else $error("phase z not routed");
    a_emg_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R7
        !function_select_reg[mpg_pkg::FUNC_EMG_BIT] |=> !emergency_out)
        else $error("emergency passes while pin is a port");
    a_ovv_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R7
        !function_select_reg[mpg_pkg::FUNC_OVV_BIT] |=> !overvoltage_out)
        else $error("overvoltage passes while pin is a port");
endmodule

// >>> mpg_pkg.sv
package mpg_pkg;
    localparam int           PIN_COUNT       = 8;
    localparam int           ADDR_WIDTH      = 6;
    // ****************************************
    // Register byte offsets from the port base
    // ****************************************
    localparam logic [5:0]   OFS_PIN_DATA    = 6'h00;
    localparam logic [5:0]   OFS_OUT_EN      = 6'h04;
    localparam logic [5:0]   OFS_FUNC_SEL    = 6'h08;
    localparam logic [5:0]   OFS_OPEN_DRAIN  = 6'h28;
    localparam logic [5:0]   OFS_PULL_UP     = 6'h2c;
    localparam logic [5:0]   OFS_PULL_DOWN   = 6'h30;
    localparam logic [5:0]   OFS_INPUT_EN    = 6'h38;
    // ****************************************
    // Reset values and field layout
    // ****************************************
    localparam logic [7:0]   RST_PORT_REG    = 8'h00;
    localparam int           DATA_LSB        = 0;
    localparam int           DATA_MSB        = 7;
    localparam int           FUNC_EMG_BIT    = 6;
    localparam int           FUNC_OVV_BIT    = 7;
    localparam logic [31:0]  UNMAPPED_READ   = 32'h0000_0000;

    typedef enum logic [0:0] {
        MPG_BUS_IDLE = 1'b0,
        MPG_BUS_DONE = 1'b1
    } mpg_bus_state_e;
endpackage

// >>> mpg_cfg_if.sv
`timescale 1ns/100ps
interface mpg_cfg_if;
    logic [7:0] out_en;
    logic [7:0] func_sel;
    logic [7:0] open_drain;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
    logic [7:0] input_en;
    logic [7:0] pin_data;

    modport regs (
        output out_en, func_sel, open_drain, pull_up, pull_down, input_en, pin_data
    );
    modport pads (
        input  out_en, func_sel, open_drain, pull_up, pull_down, input_en, pin_data
    );
endinterface

// >>> mpg_pad_mux.sv
`timescale 1ns/100ps
module mpg_pad_mux (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // Configuration
    mpg_cfg_if.pads          cfg,
    // Motor unit
    input  wire logic [5:0]  phase_in,
    // Pins
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_out,
    output logic      [7:0]  pull_up_out,
    output logic      [7:0]  pull_down_out,
    // Sampled pin levels
    output logic      [7:0]  pin_level_out
);
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] sync_c;
    logic [7:0] level;
    logic [7:0] drive_val;
    logic [7:0] drive_en;
    wire  [7:0] next_level;

    // ****************************************
    // Output path per pin
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < mpg_pkg::PIN_COUNT; g++) begin : g_pin
            // Pins 6 and 7 are motor inputs, so they never take a phase value
            if (g < 6) begin : g_phase
                assign drive_val[g] = cfg.func_sel[g] ? phase_in[g] : cfg.pin_data[g]; // see R7 R12
            end else begin : g_noph
                assign drive_val[g] = cfg.pin_data[g]; // see R12
            end
            // Open drain only pulls low; a high is left to the pull-up
            assign drive_en[g] = cfg.out_en[g] &
                                 (~cfg.open_drain[g] | ~drive_val[g]); // see R6 R8
        end
    endgenerate

    assign next_level = (sync_b == sync_c) ? (sync_c & cfg.input_en) : (level & cfg.input_en);

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            sync_a        <= mpg_pkg::RST_PORT_REG;
            sync_b        <= mpg_pkg::RST_PORT_REG;
            sync_c        <= mpg_pkg::RST_PORT_REG;
            level         <= mpg_pkg::RST_PORT_REG;
            pin_out       <= mpg_pkg::RST_PORT_REG;
            pin_oe_out    <= mpg_pkg::RST_PORT_REG;
            pull_up_out   <= mpg_pkg::RST_PORT_REG;
            pull_down_out <= mpg_pkg::RST_PORT_REG;
        end else begin
            sync_a        <= pin_in;
            sync_b        <= sync_a;
            sync_c        <= sync_b;
            level         <= next_level; // see R11
            pin_out       <= drive_val;
            pin_oe_out    <= drive_en;
            pull_up_out   <= cfg.pull_up; // see R9
            pull_down_out <= cfg.pull_down; // see R10
        end
    end

    assign pin_level_out = level;

    a_blocked_input: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R11
        (level & ~$past(cfg.input_en)) == 8'h00)
        else $error("disabled input buffer still passes level");
    a_pull_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R9
        $changed(cfg.pull_up) |=> (pull_up_out == $past(cfg.pull_up)))
        else $error("pull-up output does not follow register");
    a_pulldn_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see R10
        ##1 (pull_down_out == $past(cfg.pull_down)))
        else $error("pull-down output does not follow register");
endmodule

// >>> mpg_pin_model.sv
`timescale 1ns/100ps
module mpg_pin_model (
    // Clock
    input  wire logic        clk_in,
    // Device pad controls
    input  wire logic [7:0]  pin_out_in,
    input  wire logic [7:0]  pin_oe_in,
    input  wire logic [7:0]  pull_up_in,
    input  wire logic [7:0]  pull_down_in,
    // Outside drivers
    input  wire logic [7:0]  ext_val_in,
    input  wire logic [7:0]  ext_en_in,
    // Resolved wire level
    output logic      [7:0]  level_out
);
    logic [7:0] last_level = 8'h00;

    // A floating pin shows the inverse of its last level so stale values never pass
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_in[i]) begin
                level_out[i] = pin_out_in[i];
            end else if (ext_en_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pull_up_in[i]) begin
                level_out[i] = 1'b1;
            end else if (pull_down_in[i]) begin
                level_out[i] = 1'b0;
            end else begin
                level_out[i] = ~last_level[i];
            end
        end
    end

    always @(posedge clk_in) begin
        last_level <= level_out;
    end
endmodule

// >>> tb_motor_pin_gpio_port.sv
`timescale 1ns/100ps
module tb_motor_pin_gpio_port;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [5:0]  address = 6'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hf;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [5:0]  phase_val = 6'h00;
    logic        emergency;
    logic        overvoltage;
    logic [7:0]  pin_level;
    logic [7:0]  pin_drv;
    logic [7:0]  pin_oe;
    logic [7:0]  pull_up;
    logic [7:0]  pull_down;
    logic [7:0]  ext_val = 8'h00;
    logic [7:0]  ext_en = 8'h00;
    logic [31:0] rd;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #12.5 clk_in = ~clk_in;

    mpg_port i_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .avs_address_in(address), .avs_read_in(read), .avs_write_in(write),
        .avs_writedata_in(writedata), .avs_byteenable_in(byteenable),
        .avs_readdata_out(readdata), .avs_waitrequest_out(waitrequest),
        .phase_u_in(phase_val[0]), .phase_x_in(phase_val[1]), .phase_v_in(phase_val[2]),
        .phase_y_in(phase_val[3]), .phase_w_in(phase_val[4]), .phase_z_in(phase_val[5]),
        .emergency_out(emergency), .overvoltage_out(overvoltage),
        .pin_in(pin_level), .pin_out(pin_drv), .pin_oe_out(pin_oe),
        .pull_up_out(pull_up), .pull_down_out(pull_down)
    );

    mpg_pin_model i_pins (
        .clk_in(clk_in), .pin_out_in(pin_drv), .pin_oe_in(pin_oe),
        .pull_up_in(pull_up), .pull_down_in(pull_down),
        .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(pin_level)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Request is held until waitrequest is sampled low at a rising edge
    task automatic bus_access(input logic is_wr, input logic [5:0] a, input logic [31:0] d,
                              input logic [3:0] be);
        @(posedge clk_in);
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        read       <= ~is_wr;
        write      <= is_wr;
        @(posedge clk_in);
        while (waitrequest !== 1'b0) begin
            @(posedge clk_in);
        end
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus_access(1'b1, a, d, 4'hf);
    endtask

    task automatic rd_chk(input string name, input logic [5:0] a, input logic [31:0] exp);
        bus_access(1'b0, a, 32'h0, 4'hf);
        check(name, rd, exp);
    endtask

    task automatic test_reset();
        logic [5:0] ofs [7];
        ofs = '{mpg_pkg::OFS_PIN_DATA, mpg_pkg::OFS_OUT_EN, mpg_pkg::OFS_FUNC_SEL,
                mpg_pkg::OFS_OPEN_DRAIN, mpg_pkg::OFS_PULL_UP, mpg_pkg::OFS_PULL_DOWN,
                mpg_pkg::OFS_INPUT_EN};
        check("pins after reset", {pin_drv, pin_oe, pull_up, pull_down}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            rd_chk("reset value", ofs[i], 32'h0);
        end
        $display("test reset done");
    endtask

    task automatic test_regs();
        logic [5:0] ofs [5];
        ofs = '{6'h04, 6'h08, 6'h28, 6'h2c, 6'h30};
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 32'hdead_bea5 ^ i);
            rd_chk("config readback", ofs[i], 32'h0000_00a5 ^ i);
        end
        wr(6'h38, 32'hffff_ff3c);
        rd_chk("input enable readback", 6'h38, 32'h0000_003c);
        bus_access(1'b1, 6'h28, 32'h0000_00ff, 4'he);
        rd_chk("byteenable refused", 6'h28, 32'h0000_00a7);
        wr(6'h0c, 32'h0000_00ff);
        rd_chk("unmapped read", 6'h0c, mpg_pkg::UNMAPPED_READ);
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 32'h0);
        end
        wr(6'h38, 32'h0);
        $display("test regs done");
    endtask

    task automatic test_drive();
        wr(6'h00, 32'h0000_005a);
        wr(6'h04, 32'h0000_00ff);
        repeat (2) @(posedge clk_in);
        check("push pull drive", {pin_oe, pin_drv}, 32'h0000_ff5a);
        rd_chk("data readback", 6'h00, 32'h0000_005a);
        wr(6'h04, 32'h0000_000f);
        repeat (2) @(posedge clk_in);
        check("per bit enable", pin_oe, 32'h0000_000f);
        wr(6'h04, 32'h0000_00ff);
        wr(6'h28, 32'h0000_00ff);
        wr(6'h2c, 32'h0000_00ff);
        repeat (2) @(posedge clk_in);
        check("open drain enable", pin_oe, 32'h0000_00a5);
        check("open drain level", pin_level, 32'h0000_005a);
        wr(6'h2c, 32'h0000_00f0);
        wr(6'h30, 32'h0000_000f);
        repeat (2) @(posedge clk_in);
        check("pulls", {pull_up, pull_down}, 32'h0000_f00f);
        wr(6'h28, 32'h0);
        wr(6'h04, 32'h0);
        $display("test drive done");
    endtask

    task automatic test_input();
        ext_val <= 8'ha5;
        ext_en  <= 8'hff;
        wr(6'h38, 32'h0000_003c);
        repeat (10) @(posedge clk_in);
        rd_chk("masked input", 6'h00, 32'h0000_0024);
        $display("test input done");
    endtask

    task automatic test_motor();
        phase_val <= 6'h2d;
        ext_val   <= 8'hc0;
        wr(6'h38, 32'h0000_00c0);
        wr(6'h04, 32'h0000_003f);
        wr(6'h08, 32'h0000_00ff);
        repeat (10) @(posedge clk_in);
        check("phase pins", {pin_oe[5:0], pin_drv[5:0]}, 32'h0000_0fed);
        check("protection", {emergency, overvoltage}, 32'h3);
        wr(6'h08, 32'h0000_007f);
        repeat (10) @(posedge clk_in);
        check("overvoltage off", {emergency, overvoltage}, 32'h2);
        wr(6'h08, 32'h0000_0000);
        repeat (3) @(posedge clk_in);
        check("port mode again", pin_drv[5:0], 32'h0000_001a);
        $display("test motor done");
    endtask

    // Whole run is well under a thousand cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        test_reset();
        test_regs();
        test_drive();
        test_input();
        test_motor();
        tally_and_finish();
    end
endmodule
